//--- inc/sis_pkg.sv
`default_nettype none
package sis_pkg;
  // ****************************************
  // i/o space offsets
  // ****************************************
  localparam logic [5:0] SIS_OFS_PTR_LO = 6'h00;
  localparam logic [5:0] SIS_OFS_PTR_HI = 6'h01;
  localparam logic [5:0] SIS_OFS_STATUS = 6'h02;
  localparam logic [5:0] SIS_OFS_FLAG = 6'h03;
  localparam logic [5:0] SIS_OFS_ENABLE = 6'h04;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int unsigned SIS_GIE_BIT = 7;
  localparam logic [15:0] SIS_PTR_RESET = 16'h02ff;
  localparam logic [7:0] SIS_STATUS_RESET = 8'h00;
  localparam logic [7:0] SIS_VEC_BASE = 8'h01;

  // ****************************************
  // timing counts, in clock cycles
  // ****************************************
  localparam logic [15:0] SIS_ENTRY_LAST = 16'h0003;
  localparam logic [15:0] SIS_RETURN_LAST = 16'h0003;
  localparam int unsigned SIS_WAKE_EXTRA = 4;
  localparam int unsigned SIS_STARTUP_CYC = 16;

  typedef enum {ST_RUN, ST_WAKE, ST_ENT, ST_EXIT} sis_state_t;

  typedef struct packed {
    logic push1;
    logic pop1;
    logic call;
    logic sub_return;
    logic irq_return;
    logic sei;
    logic cli;
    logic instr_done;
  } sis_cpu_evt_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } sis_io_req_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } sis_mem_req_t;
endpackage : sis_pkg
`default_nettype wire

//--- core/sis_prio.sv
`default_nettype none
module sis_prio #(
  parameter int unsigned N = 8,
  parameter int unsigned IW = (N > 1) ? $clog2(N) : 1
) (
  input wire logic [N-1:0] req,
  output logic any,
  output logic [IW-1:0] idx
);
  // ****************************************
  // lowest index wins
  // ****************************************
  always_comb
  begin
    any = |req;
    idx = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        idx = IW'(i);
      end
    end
  end
endmodule : sis_prio
`default_nettype wire

//--- core/sis_top.sv
// Behaviour
// - push writes byte, then lowers pointer by one
// - call or interrupt entry lowers pointer by two
// - single pop raises pointer by one
// - return instructions raise pointer by two
// - pointer held as two writable readable bytes
// - take only with own and global enable
// - lowest vector first; request zero after reset
// - entry clears global interrupt enable
// - interrupt return sets global enable
// - vectoring clears the request flag
// - writing one clears a flag
// - disabled flag requests stay latched
// - level requests only while condition present
// - one instruction after return before next
// - disable instruction blocks same-cycle requests
// - enable instruction: next instruction runs first
// - entry takes four cycles pushing counter
// - multi-cycle instruction completes before entry
// - wake from sleep adds start-up time plus four cycles
// - return takes four cycles, pops two bytes
// - status register never saved automatically
// - global enable at status bit seven
`default_nettype none
module sis_top #(
  parameter int unsigned NSRC = 8,
  parameter logic [NSRC-1:0] FLAG_MASK = '1,
  parameter logic [15:0] PTR_RESET = sis_pkg::SIS_PTR_RESET,
  parameter int unsigned STARTUP_CYC = sis_pkg::SIS_STARTUP_CYC
) (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic CE,
  input wire sis_pkg::sis_io_req_t IO_REQ,
  output logic [7:0] IO_RDATA,
  input wire sis_pkg::sis_cpu_evt_t CPU_EVT,
  input wire logic SLEEP_ACTIVE,
  input wire logic [15:0] PC_IN,
  input wire logic [NSRC-1:0] IRQ_SRC,
  output sis_pkg::sis_mem_req_t MEM_REQ,
  input wire logic [7:0] MEM_RDATA,
  output logic [15:0] STACK_PTR,
  output logic GLOBAL_IRQ_EN,
  output logic STALL,
  output logic WAKE,
  output logic VEC_TAKE,
  output logic [7:0] VEC_NUM,
  output logic PC_LOAD,
  output logic [15:0] PC_OUT
);
  import sis_pkg::*;

  localparam int unsigned IW = (NSRC > 1) ? $clog2(NSRC) : 1;
  localparam logic [15:0] WAKE_LAST = 16'(STARTUP_CYC + SIS_WAKE_EXTRA - 1);

  logic rst_meta_q;
  logic rst_b_q;
  sis_state_t state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] ptr_q, ptr_d;
  logic i_q, i_d;
  logic [6:0] status_lo_q;
  logic hold_q;
  logic [NSRC-1:0] flag_q;
  logic [NSRC-1:0] en_q;
  logic [NSRC-1:0] pending;
  logic [NSRC-1:0] armed;
  logic any_armed;
  logic [IW-1:0] arb_idx;
  logic [IW-1:0] vec_idx_q;
  logic [15:0] pc_save_q;
  logic [7:0] flag_rd;
  logic [7:0] en_rd;
  logic wr_ptr_lo, wr_ptr_hi, wr_status, wr_flag, wr_en;
  logic run, take_ok, go_wake, go_ent, exit_start, clr_by_sw;

  // ****************************************
  // reset release
  // ****************************************
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rst_meta_q <= 1'b0;
      rst_b_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_b_q <= rst_meta_q;
    end
  end

  // ****************************************
  // decode and take decision
  // ****************************************
  assign wr_ptr_lo = IO_REQ.wr && (IO_REQ.addr == SIS_OFS_PTR_LO);
  assign wr_ptr_hi = IO_REQ.wr && (IO_REQ.addr == SIS_OFS_PTR_HI);
  assign wr_status = IO_REQ.wr && (IO_REQ.addr == SIS_OFS_STATUS);
  assign wr_flag = IO_REQ.wr && (IO_REQ.addr == SIS_OFS_FLAG);
  assign wr_en = IO_REQ.wr && (IO_REQ.addr == SIS_OFS_ENABLE);
  assign run = (state_q == ST_RUN);
  assign clr_by_sw = wr_status && !IO_REQ.wdata[SIS_GIE_BIT];

  assign armed = pending & en_q;

  sis_prio #(
    .N(NSRC),
    .IW(IW)
  ) u_prio (
    .req(armed),
    .any(any_armed),
    .idx(arb_idx)
  );

  // requests are looked at only on an instruction boundary or while asleep,
  // so a multi-cycle instruction always finishes first
  assign take_ok = run && i_q && any_armed && !CPU_EVT.cli && !clr_by_sw
                   && !hold_q && !CPU_EVT.sei
                   && (CPU_EVT.instr_done || SLEEP_ACTIVE);
  assign go_wake = take_ok && SLEEP_ACTIVE;
  assign go_ent = take_ok && !SLEEP_ACTIVE;
  assign exit_start = run && CPU_EVT.irq_return && !take_ok;

  // ****************************************
  // sequencer
  // ****************************************
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_RUN:
      begin
        cnt_d = 16'h0000;
        if (go_wake)
        begin
          state_d = ST_WAKE;
        end
        else if (go_ent)
        begin
          state_d = ST_ENT;
        end
        else if (exit_start)
        begin
          state_d = ST_EXIT;
        end
      end
      ST_WAKE:
      begin
        // start-up time plus four extra cycles before the entry proper
        if (cnt_q == WAKE_LAST)
        begin
          state_d = ST_ENT;
          cnt_d = 16'h0000;
        end
        else
        begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      ST_ENT:
      begin
        if (cnt_q == SIS_ENTRY_LAST)
        begin
          state_d = ST_RUN;
        end
        else
        begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      ST_EXIT:
      begin
        if (cnt_q == SIS_RETURN_LAST)
        begin
          state_d = ST_RUN;
        end
        else
        begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      default:
      begin
        state_d = ST_RUN;
        cnt_d = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge rst_b_q)
  begin
    if (!rst_b_q)
    begin
      state_q <= ST_RUN;
      cnt_q <= 16'h0000;
      STALL <= 1'b0;
      WAKE <= 1'b0;
    end
    else if (CE)
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      STALL <= (state_d != ST_RUN);
      WAKE <= (state_d == ST_WAKE);
    end
  end

  // ****************************************
  // stack pointer
  // ****************************************
  // the pipeline is stalled during a sequence, so its events never clash
  // with the sequencer's own pointer steps
  always_comb
  begin
    ptr_d = ptr_q;
    if ((state_q == ST_ENT) && (cnt_q < 16'h0002))
    begin
      ptr_d = ptr_q - 16'h0001;
    end
    else if ((state_q == ST_EXIT) && (cnt_q < 16'h0002))
    begin
      ptr_d = ptr_q + 16'h0001;
    end
    else if (run && (wr_ptr_lo || wr_ptr_hi))
    begin
      // software must place the stack above 0x60 before calls or interrupts
      ptr_d = {wr_ptr_hi ? IO_REQ.wdata : ptr_q[15:8],
               wr_ptr_lo ? IO_REQ.wdata : ptr_q[7:0]};
    end
    else if (run && CPU_EVT.push1)
    begin
      ptr_d = ptr_q - 16'h0001;
    end
    else if (run && CPU_EVT.call)
    begin
      ptr_d = ptr_q - 16'h0002;
    end
    else if (run && CPU_EVT.pop1)
    begin
      ptr_d = ptr_q + 16'h0001;
    end
    else if (run && CPU_EVT.sub_return)
    begin
      ptr_d = ptr_q + 16'h0002;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_b_q)
  begin
    if (!rst_b_q)
    begin
      ptr_q <= PTR_RESET;
    end
    else if (CE)
    begin
      ptr_q <= ptr_d;
    end
  end
  assign STACK_PTR = ptr_q;

  // ****************************************
  // status register and enable hold-off
  // ****************************************
  // entry and return leave the low status bits alone; software saves them
  always_comb
  begin
    i_d = i_q;
    if (run && wr_status)
    begin
      i_d = IO_REQ.wdata[SIS_GIE_BIT];
    end
    if (run && CPU_EVT.sei)
    begin
      i_d = 1'b1;
    end
    if (run && CPU_EVT.cli)
    begin
      i_d = 1'b0;
    end
    if (go_ent || go_wake)
    begin
      i_d = 1'b0;
    end
    if ((state_q == ST_EXIT) && (cnt_q == SIS_RETURN_LAST))
    begin
      i_d = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_b_q)
  begin
    if (!rst_b_q)
    begin
      i_q <= SIS_STATUS_RESET[SIS_GIE_BIT];
      status_lo_q <= SIS_STATUS_RESET[6:0];
      hold_q <= 1'b0;
    end
    else if (CE)
    begin
      i_q <= i_d;
      if (run && wr_status)
      begin
        status_lo_q <= IO_REQ.wdata[6:0];
      end
      if ((state_q == ST_EXIT) && (cnt_q == SIS_RETURN_LAST))
      begin
        hold_q <= 1'b1;
      end
      else if (run && CPU_EVT.sei)
      begin
        hold_q <= 1'b1;
      end
      else if (run && CPU_EVT.instr_done)
      begin
        hold_q <= 1'b0;
      end
    end
  end
  assign GLOBAL_IRQ_EN = i_q;

  // ****************************************
  // request sources
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NSRC; g++)
    begin : g_src
      logic set_g, clr_g;
      assign set_g = FLAG_MASK[g] && IRQ_SRC[g];
      assign clr_g = (wr_flag && IO_REQ.wdata[g])
                     || (take_ok && (arb_idx == IW'(g)));
      // a source event in the clearing cycle survives: set beats clear
      always_ff @(posedge CLOCK or negedge rst_b_q)
      begin
        if (!rst_b_q)
        begin
          flag_q[g] <= 1'b0;
        end
        else if (CE)
        begin
          flag_q[g] <= set_g || (flag_q[g] && !clr_g);
        end
      end
      assign pending[g] = FLAG_MASK[g] ? flag_q[g] : IRQ_SRC[g];

      a_flag_w1c: assert property (@(posedge CLOCK) disable iff (!rst_b_q || !CE)
        (wr_flag && IO_REQ.wdata[g] && !set_g) |=> !flag_q[g])
        else $error("flag not cleared by write of one");
      a_flag_latched: assert property (@(posedge CLOCK) disable iff (!rst_b_q || !CE)
        (flag_q[g] && !clr_g) |=> flag_q[g])
        else $error("latched flag lost");
    end
  endgenerate

  always_ff @(posedge CLOCK or negedge rst_b_q)
  begin
    if (!rst_b_q)
    begin
      en_q <= '0;
    end
    else if (CE && wr_en)
    begin
      en_q <= IO_REQ.wdata[NSRC-1:0];
    end
  end

  // ****************************************
  // entry and return data path
  // ****************************************
  // the counter is pushed low byte first; the pop order mirrors it
  always_ff @(posedge CLOCK or negedge rst_b_q)
  begin
    if (!rst_b_q)
    begin
      MEM_REQ <= '0;
      pc_save_q <= 16'h0000;
      vec_idx_q <= '0;
      VEC_TAKE <= 1'b0;
      VEC_NUM <= 8'h00;
      PC_LOAD <= 1'b0;
      PC_OUT <= 16'h0000;
    end
    else if (CE)
    begin
      MEM_REQ <= '0;
      VEC_TAKE <= 1'b0;
      PC_LOAD <= 1'b0;
      if (take_ok)
      begin
        pc_save_q <= PC_IN;
        vec_idx_q <= arb_idx;
      end
      if ((state_q == ST_ENT) && (cnt_q < 16'h0002))
      begin
        MEM_REQ.wr <= 1'b1;
        MEM_REQ.addr <= ptr_q;
        MEM_REQ.wdata <= cnt_q[0] ? pc_save_q[15:8] : pc_save_q[7:0];
      end
      if ((state_q == ST_EXIT) && (cnt_q < 16'h0002))
      begin
        MEM_REQ.rd <= 1'b1;
        MEM_REQ.addr <= ptr_q + 16'h0001;
      end
      if ((state_q == ST_EXIT) && (cnt_q == 16'h0002))
      begin
        PC_OUT[15:8] <= MEM_RDATA;
      end
      if ((state_q == ST_EXIT) && (cnt_q == SIS_RETURN_LAST))
      begin
        PC_OUT[7:0] <= MEM_RDATA;
        PC_LOAD <= 1'b1;
      end
      if ((state_q == ST_ENT) && (cnt_q == SIS_ENTRY_LAST))
      begin
        VEC_TAKE <= 1'b1;
        VEC_NUM <= SIS_VEC_BASE + 8'(vec_idx_q);
      end
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  always_comb
  begin
    flag_rd = 8'h00;
    en_rd = 8'h00;
    flag_rd[NSRC-1:0] = flag_q;
    en_rd[NSRC-1:0] = en_q;
  end

  always_ff @(posedge CLOCK or negedge rst_b_q)
  begin
    if (!rst_b_q)
    begin
      IO_RDATA <= 8'h00;
    end
    else if (CE && IO_REQ.rd)
    begin
      case (IO_REQ.addr)
        SIS_OFS_PTR_LO: IO_RDATA <= ptr_q[7:0];
        SIS_OFS_PTR_HI: IO_RDATA <= ptr_q[15:8];
        SIS_OFS_STATUS: IO_RDATA <= {i_q, status_lo_q};
        SIS_OFS_FLAG: IO_RDATA <= flag_rd;
        SIS_OFS_ENABLE: IO_RDATA <= en_rd;
        default: IO_RDATA <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_push_one: assert property (@(posedge CLOCK) disable iff (!rst_b_q || !CE)
    (run && CPU_EVT.push1 && !wr_ptr_lo && !wr_ptr_hi) |=> (ptr_q == $past(ptr_q) - 16'h0001))
    else $error("push did not lower pointer by one");
  a_call_two: assert property (@(posedge CLOCK) disable iff (!rst_b_q || !CE)
    (run && CPU_EVT.call && !CPU_EVT.push1 && !wr_ptr_lo && !wr_ptr_hi)
      |=> (ptr_q == $past(ptr_q) - 16'h0002))
    else $error("call did not lower pointer by two");
  a_pop_one: assert property (@(posedge CLOCK) disable iff (!rst_b_q || !CE)
    (run && CPU_EVT.pop1 && !CPU_EVT.push1 && !CPU_EVT.call && !wr_ptr_lo && !wr_ptr_hi)
      |=> (ptr_q == $past(ptr_q) + 16'h0001))
    else $error("pop did not raise pointer by one");
  a_return_from_irq_instr_seq: assert property (@(posedge CLOCK) disable iff (!rst_b_q || !CE)
    exit_start |-> ##5 (run && i_q && PC_LOAD && (ptr_q == $past(ptr_q, 5) + 16'h0002)))
    else $error("return sequence wrong");
  a_entry_len: assert property (@(posedge CLOCK) disable iff (!rst_b_q || !CE)
    go_ent |=> (state_q == ST_ENT)[*4] ##1 (VEC_TAKE && (ptr_q == $past(ptr_q, 5) - 16'h0002)))
    else $error("entry sequence wrong");
  a_entry_gie: assert property (@(posedge CLOCK) disable iff (!rst_b_q || !CE)
    take_ok |=> !i_q)
    else $error("entry kept global enable");
  a_cli_block: assert property (@(posedge CLOCK) disable iff (!rst_b_q || !CE)
    CPU_EVT.cli |-> !take_ok)
    else $error("request taken with disable instruction");
  a_sei_next: assert property (@(posedge CLOCK) disable iff (!rst_b_q || !CE)
    (run && CPU_EVT.sei) |-> !take_ok ##1 !take_ok)
    else $error("request taken right after enable instruction");
  a_take_enabled: assert property (@(posedge CLOCK) disable iff (!rst_b_q || !CE)
    take_ok |-> (i_q && ((pending & en_q) != '0)))
    else $error("request taken while disabled");
  a_prio_zero: assert property (@(posedge CLOCK) disable iff (!rst_b_q || !CE)
    (take_ok && armed[0]) |=> (vec_idx_q == '0))
    else $error("request zero not first");
  a_wake_extra: assert property (@(posedge CLOCK) disable iff (!rst_b_q || !CE)
    go_wake |=> (state_q == ST_WAKE)[*4])
    else $error("wake response too short");
endmodule : sis_top
`default_nettype wire

//--- dv/sis_mem_model.sv
`default_nettype none
module sis_mem_model
(
  input wire logic clk,
  input wire sis_pkg::sis_mem_req_t mem_req,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import sis_pkg::*;
  // ****************************************
  // stack sram
  // ****************************************
  logic [7:0] mem [0:65535];
  logic [7:0] rdata_q = 8'h5a;
  assign mem_rdata = rdata_q;
  // read data is valid for one cycle only; after that the bus wanders so stale use shows
  always @(posedge clk)
  begin
    if (mem_req.wr)
      mem[mem_req.addr] <= mem_req.wdata;
    if (mem_req.rd)
      rdata_q <= mem[mem_req.addr];
    else
      rdata_q <= ~rdata_q;
  end
endmodule : sis_mem_model
`default_nettype wire

//--- dv/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sis_pkg::*;
  // ****************************************
  // stimulus and design
  // ****************************************
  localparam int unsigned STARTUP = 1;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  sis_io_req_t io_req = '0;
  sis_cpu_evt_t cpu_evt = '0;
  logic sleep_active = 1'b0;
  logic [15:0] pc_in = '0;
  logic [7:0] irq_src = '0;
  sis_mem_req_t mem_req;
  logic [7:0] mem_rdata, io_rdata, vec_num, r, e, st, x, m;
  logic [15:0] stack_ptr, pc_out, exp_ptr;
  logic gie, stall, wake, vec_take, pc_load;
  int fail_count = 0;
  int cmp_count = 0;
  int seed = 74;
  int n, w;
  always #2.5 clk = ~clk;
  sis_top #(.NSRC(8), .FLAG_MASK(8'h7f), .STARTUP_CYC(STARTUP)) i_sis_top (
    .CLOCK(clk), .RST_B(rst_b), .CE(1'b1), .IO_REQ(io_req), .IO_RDATA(io_rdata),
    .CPU_EVT(cpu_evt), .SLEEP_ACTIVE(sleep_active), .PC_IN(pc_in), .IRQ_SRC(irq_src),
    .MEM_REQ(mem_req), .MEM_RDATA(mem_rdata), .STACK_PTR(stack_ptr),
    .GLOBAL_IRQ_EN(gie), .STALL(stall), .WAKE(wake), .VEC_TAKE(vec_take),
    .VEC_NUM(vec_num), .PC_LOAD(pc_load), .PC_OUT(pc_out));
  sis_mem_model i_sis_mem_model (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata));
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk
  task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    io_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    io_req <= '0;
  endtask : io_wr
  task automatic io_rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    io_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    io_req <= '0;
    #1;
    d = io_rdata;
  endtask : io_rd
  task automatic evt(input logic [7:0] ev);
    @(posedge clk);
    cpu_evt <= sis_cpu_evt_t'(ev);
    @(posedge clk);
    cpu_evt <= '0;
    #1;
  endtask : evt
  task automatic pulse(input logic [7:0] mk);
    @(posedge clk);
    irq_src <= mk;
    pc_in <= 16'($random(seed));
    @(posedge clk);
    irq_src <= '0;
  endtask : pulse
  // counts cycles from the first sequencer cycle to the vector or reload pulse
  task automatic run(input bit for_exit);
    n = 0;
    w = 0;
    while (((for_exit ? pc_load : vec_take) !== 1'b1) && n < 300)
    begin
      if (wake === 1'b1)
        w++;
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 300)
      chk(16'(n), 16'd0, "sequence never ended");
  endtask : run
  function automatic logic [7:0] first_vec(input logic [7:0] mk);
    for (int i = 0; i < 8; i++)
      if (mk[i])
        return 8'(i + 1);
    return 8'h00;
  endfunction : first_vec
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // ****************************************
  // sequence
  // ****************************************
  initial
  begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(stack_ptr, SIS_PTR_RESET, "pointer reset");
    io_rd(SIS_OFS_PTR_LO, x);
    chk(x, SIS_PTR_RESET[7:0], "low byte reset");
    io_rd(SIS_OFS_PTR_HI, x);
    chk(x, SIS_PTR_RESET[15:8], "high byte reset");
    io_rd(6'h3f, x);
    chk(x, 8'h00, "unmapped read");
    $display("test reset done");
    exp_ptr = {8'h02, 8'($random(seed))};
    io_wr(SIS_OFS_PTR_LO, exp_ptr[7:0]);
    io_wr(SIS_OFS_PTR_HI, exp_ptr[15:8]);
    #1 chk(stack_ptr, exp_ptr, "pointer write");
    for (int k = 0; k < 24; k++)
    begin
      r = 8'h80 >> ($unsigned($random(seed)) % 4);
      evt(r);
      exp_ptr = exp_ptr - (r[7] ? 16'd1 : r[5] ? 16'd2 : r[6] ? -16'd1 : -16'd2);
      chk(stack_ptr, exp_ptr, "pointer step");
    end
    io_rd(SIS_OFS_PTR_LO, x);
    chk(x, exp_ptr[7:0], "low byte read");
    io_rd(SIS_OFS_PTR_HI, x);
    chk(x, exp_ptr[15:8], "high byte read");
    $display("test pointer done");
    for (int k = 0; k < 4; k++)
    begin
      r = (k == 0) ? 8'h7f : ((8'($random(seed)) & 8'h7f) | 8'h40);
      e = (k == 0) ? 8'h7e : (8'($random(seed)) | 8'h40);
      st = 8'($random(seed)) & 8'h7f;
      m = r & ~(8'h01 << (first_vec(r & e) - 8'h01));
      pulse(r);
      io_wr(SIS_OFS_ENABLE, e);
      io_wr(SIS_OFS_STATUS, st | 8'h80);
      io_rd(SIS_OFS_STATUS, x);
      chk({7'h00, gie, x}, {8'h01, st | 8'h80}, "enable bit");
      chk(stall, 1'b0, "no entry before instruction end");
      evt(8'h01);
      run(0);
      chk(16'(n), 16'd4, "entry cycles");
      chk(vec_num, first_vec(r & e), "vector");
      chk(gie, 1'b0, "enable after entry");
      chk(stack_ptr, exp_ptr - 16'd2, "entry pointer");
      chk(i_sis_mem_model.mem[exp_ptr], pc_in[7:0], "pushed low");
      chk(i_sis_mem_model.mem[exp_ptr - 16'd1], pc_in[15:8], "pushed high");
      io_rd(SIS_OFS_STATUS, x);
      chk(x, st, "status kept");
      io_rd(SIS_OFS_FLAG, x);
      chk(x, m, "flag after vectoring");
      evt(8'h09);
      run(1);
      chk(16'(n), 16'd4, "return cycles");
      chk(pc_out, pc_in, "return address");
      chk(stack_ptr, exp_ptr, "return pointer");
      chk(gie, 1'b1, "enable after return");
      evt(8'h01);
      repeat (2) @(posedge clk);
      #1 chk(stall, 1'b0, "held after return");
      io_wr(SIS_OFS_FLAG, 8'h00);
      io_rd(SIS_OFS_FLAG, x);
      chk(x, m, "zero write keeps flags");
      io_wr(SIS_OFS_FLAG, 8'hff);
      io_rd(SIS_OFS_FLAG, x);
      chk(x, 8'h00, "one write clears flags");
    end
    $display("test entry and return done");
    pulse(8'h04);
    io_wr(SIS_OFS_ENABLE, 8'hff);
    io_wr(SIS_OFS_STATUS, 8'h80);
    evt(8'h03);
    repeat (2) @(posedge clk);
    #1 chk({gie, stall}, 2'b00, "disable same cycle");
    evt(8'h05);
    repeat (2) @(posedge clk);
    #1 chk({gie, stall}, 2'b10, "enable waits one instruction");
    evt(8'h01);
    repeat (2) @(posedge clk);
    #1 chk(stall, 1'b0, "held for the next instruction");
    evt(8'h01);
    run(0);
    chk(vec_num, 8'h03, "vector after enable");
    evt(8'h09);
    run(1);
    $display("test disable and enable done");
    io_wr(SIS_OFS_STATUS, 8'h00);
    pulse(8'h80);
    io_wr(SIS_OFS_STATUS, 8'h80);
    evt(8'h01);
    evt(8'h01);
    repeat (2) @(posedge clk);
    #1 chk(stall, 1'b0, "vanished level");
    @(posedge clk);
    irq_src <= 8'h80;
    evt(8'h01);
    run(0);
    chk(vec_num, 8'h08, "level vector");
    @(posedge clk);
    irq_src <= '0;
    evt(8'h09);
    run(1);
    evt(8'h01);
    $display("test level done");
    @(posedge clk);
    sleep_active <= 1'b1;
    pulse(8'h01);
    for (n = 0; n < 50 && wake !== 1'b1; n++)
      @(posedge clk) #1;
    run(0);
    chk(16'(w), 16'(STARTUP + 4), "wake cycles");
    chk(16'(n), 16'(STARTUP + 8), "wake entry cycles");
    @(posedge clk);
    sleep_active <= 1'b0;
    evt(8'h09);
    run(1);
    chk(stack_ptr, exp_ptr, "pointer after wake");
    $display("test sleep done");
    print_verdict();
  end
  initial
  begin
    #100000;
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
